/* core/vdnc_params.svh */
`ifndef VDNC_PARAMS_SVH
`define VDNC_PARAMS_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define VDNC_OFS_CONTROL 16'h0000
`define VDNC_OFS_STATUS 16'h0004
`define VDNC_OFS_VERSION 16'h0010
`define VDNC_OFS_FRAME_DIM 16'h0100
`define VDNC_OFS_TBL_DATA 16'h0104
`define VDNC_OFS_ACT_BANK 16'h0108
`define VDNC_OFS_WR_BANK 16'h010c

// ************************************************************
// Field positions
// ************************************************************
`define VDNC_CTRL_ENABLE 0
`define VDNC_CTRL_COMMIT 1
`define VDNC_CTRL_BYPASS 2
`define VDNC_CTRL_SWRST 31
`define VDNC_STAT_DONE 0
`define VDNC_PIX_MSB 12
`define VDNC_PIX_LSB 0
`define VDNC_LIN_MSB 28
`define VDNC_LIN_LSB 16
`define VDNC_BANK_MSB 2
`define VDNC_BYTE_MSB 7

// ************************************************************
// Reset values and counts
// ************************************************************
`define VDNC_RST_CONTROL 32'h0000_0000
`define VDNC_RST_WR_BANK 3'h0
`define VDNC_TBL_LAST 7'h7f
`define VDNC_TBL_LUMA_ENTRIES 64

`endif

/* core/vdnc_pkg.sv */
`default_nettype none
package vdnc_pkg;
   typedef logic [12:0] vdnc_dim_t;
   typedef logic [2:0] vdnc_bank_t;
   typedef logic [6:0] vdnc_idx_t;
   typedef logic [9:0] vdnc_taddr_t;
   typedef logic [7:0] vdnc_byte_t;

   // Loader: accepting entries, or all 128 received
   typedef enum logic [0:0] {
      VDNC_LD_RUN = 1'b0,
      VDNC_LD_FULL = 1'b1
   } vdnc_load_e;
endpackage : vdnc_pkg
`default_nettype wire

/* core/vdnc_tbl_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface vdnc_tbl_if;
   logic wr_en;
   vdnc_pkg::vdnc_taddr_t wr_addr;
   vdnc_pkg::vdnc_byte_t wr_data;
   vdnc_pkg::vdnc_taddr_t rd_addr;
   vdnc_pkg::vdnc_byte_t rd_data;

   modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
   modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : vdnc_tbl_if
`default_nettype wire

/* core/vdnc_table_mem.sv */
`timescale 1ns/10ps
`default_nettype none
module vdnc_table_mem #(
   parameter int DEPTH = 1024
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Table ports
   vdnc_tbl_if.mem tbl
);
   vdnc_pkg::vdnc_byte_t mem_ff [DEPTH];
   vdnc_pkg::vdnc_byte_t rd_data_ff;
   vdnc_pkg::vdnc_byte_t nxt_rd_data;

   always_comb begin
      nxt_rd_data = mem_ff[tbl.rd_addr];
   end

   // Array has no reset: contents are only meaningful once loaded
   always_ff @(posedge sys_clk) begin
      if (tbl.wr_en) begin
         mem_ff[tbl.wr_addr] <= tbl.wr_data;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data_ff <= 8'h00;
      end else begin
         rd_data_ff <= nxt_rd_data;
      end
   end

   assign tbl.rd_data = rd_data_ff;
endmodule : vdnc_table_mem
`default_nettype wire

/* core/vdnc_regs.sv */
// Contract
// - Control bit 0 enables processing, clear halts
// - Enable bit resets to zero
// - Enable change acts immediately, no frame alignment
// - Processor copies commit at frame end if semaphore
// - Frame size and table registers double-buffered
// - Control bit 2 set bypasses noise reduction
// - Control bit 31 holds everything at defaults
// - Software reset unaligned; avoid mid-frame
// - Read-only version register with five fields
// - Frame size fields, parameter reset values
// - Table data register takes byte per write
// - Active bank select, parameter reset value
// - Write bank select, reset zero
// - Status bits sticky, cleared by writing one
// - Write bank write restarts load at zero
// - 128 entries loaded sets load-done status
// - Active bank changes only after frame end, or at once on soft reset
`timescale 1ns/10ps
`default_nettype none
`include "vdnc_params.svh"
module vdnc_regs #(
   parameter logic [12:0] DEF_PIXELS = 13'h0780,
   parameter logic [12:0] DEF_LINES = 13'h0438,
   parameter logic [2:0] DEF_ACT_BANK = 3'h0,
   // Identification fields: values are arbitrary
   parameter logic [7:0] VER_MAJOR = 8'h01,
   parameter logic [7:0] VER_MINOR = 8'h00,
   parameter logic [3:0] VER_REVISION = 4'h0,
   parameter logic [3:0] VER_PATCH = 4'h0,
   parameter logic [7:0] VER_REV_NUM = 8'h00
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Register port
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [15:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic reg_rd_valid,
   // Stream timing
   input wire logic frame_end,
   // Table lookup for the filter
   input wire logic [6:0] tbl_lookup_idx,
   output logic [7:0] tbl_lookup_data,
   // Core controls
   output logic processing_enable,
   output logic filter_bypass,
   output logic core_reset,
   output logic [12:0] active_pixels,
   output logic [12:0] active_lines,
   output logic [2:0] active_bank,
   output logic [2:0] active_write_bank
);
   // ************************************************************
   // State
   // ************************************************************
   logic enable_ff, nxt_enable;
   logic commit_ff, nxt_commit;
   logic bypass_ff, nxt_bypass;
   logic swrst_ff, nxt_swrst;
   logic done_ff, nxt_done;
   vdnc_pkg::vdnc_load_e load_st_ff, nxt_load_st;
   vdnc_pkg::vdnc_idx_t load_cnt_ff, nxt_load_cnt;
   vdnc_pkg::vdnc_dim_t pix_sh_ff, nxt_pix_sh, pix_act_ff, nxt_pix_act;
   vdnc_pkg::vdnc_dim_t lin_sh_ff, nxt_lin_sh, lin_act_ff, nxt_lin_act;
   vdnc_pkg::vdnc_bank_t abank_sh_ff, nxt_abank_sh, abank_act_ff, nxt_abank_act;
   vdnc_pkg::vdnc_bank_t wbank_sh_ff, nxt_wbank_sh, wbank_act_ff, nxt_wbank_act;
   logic [31:0] rdata_ff, nxt_rdata;
   logic rd_valid_ff;
   logic wr_ctrl, wr_stat, wr_dim, wr_din, wr_abank, wr_wbank, load_accept;

   vdnc_tbl_if tbl ();

   function automatic logic hit(input logic [15:0] addr, input logic [15:0] ofs);
      hit = (addr == ofs);
   endfunction : hit

   function automatic logic [31:0] ctrl_word(input logic sw, input logic by,
                                             input logic cm, input logic en);
      ctrl_word = {sw, 28'h0000000, by, cm, en};
   endfunction : ctrl_word

   assign wr_ctrl = reg_wr_en && hit(reg_addr, `VDNC_OFS_CONTROL);
   assign wr_stat = reg_wr_en && hit(reg_addr, `VDNC_OFS_STATUS);
   assign wr_dim = reg_wr_en && hit(reg_addr, `VDNC_OFS_FRAME_DIM);
   assign wr_din = reg_wr_en && hit(reg_addr, `VDNC_OFS_TBL_DATA);
   assign wr_abank = reg_wr_en && hit(reg_addr, `VDNC_OFS_ACT_BANK);
   assign wr_wbank = reg_wr_en && hit(reg_addr, `VDNC_OFS_WR_BANK);
   // Writes land in the processor-side bank copy; loading is a processor action
   assign load_accept = wr_din && (load_st_ff == vdnc_pkg::VDNC_LD_RUN) && !swrst_ff;

   // ************************************************************
   // Register next state
   // ************************************************************
   always_comb begin
      nxt_enable = enable_ff;
      nxt_commit = commit_ff;
      nxt_bypass = bypass_ff;
      nxt_swrst = swrst_ff;
      nxt_done = done_ff;
      nxt_load_st = load_st_ff;
      nxt_load_cnt = load_cnt_ff;
      nxt_pix_sh = pix_sh_ff;
      nxt_lin_sh = lin_sh_ff;
      nxt_abank_sh = abank_sh_ff;
      nxt_wbank_sh = wbank_sh_ff;
      nxt_pix_act = pix_act_ff;
      nxt_lin_act = lin_act_ff;
      nxt_abank_act = abank_act_ff;
      nxt_wbank_act = wbank_act_ff;
      // Only the four defined bits are stored; reserved bits drop
      if (wr_ctrl) begin
         nxt_enable = reg_wdata[`VDNC_CTRL_ENABLE];
         nxt_commit = reg_wdata[`VDNC_CTRL_COMMIT];
         nxt_bypass = reg_wdata[`VDNC_CTRL_BYPASS];
         nxt_swrst = reg_wdata[`VDNC_CTRL_SWRST];
      end
      if (wr_stat && reg_wdata[`VDNC_STAT_DONE]) begin
         nxt_done = 1'b0;
      end
      if (wr_dim) begin
         nxt_pix_sh = reg_wdata[`VDNC_PIX_MSB:`VDNC_PIX_LSB];
         nxt_lin_sh = reg_wdata[`VDNC_LIN_MSB:`VDNC_LIN_LSB];
      end
      if (wr_abank) begin
         nxt_abank_sh = reg_wdata[`VDNC_BANK_MSB:0];
      end
      if (wr_wbank) begin
         nxt_wbank_sh = reg_wdata[`VDNC_BANK_MSB:0];
         nxt_load_cnt = 7'h00;
         nxt_load_st = vdnc_pkg::VDNC_LD_RUN;
      end
      if (load_accept) begin
         case (load_st_ff)
            vdnc_pkg::VDNC_LD_RUN: begin
               nxt_load_cnt = load_cnt_ff + 7'h01;
               if (load_cnt_ff == `VDNC_TBL_LAST) begin
                  nxt_load_st = vdnc_pkg::VDNC_LD_FULL;
                  // Completion beats a same-cycle clear
                  nxt_done = 1'b1;
               end
            end
            default: begin
               nxt_load_cnt = load_cnt_ff;
            end
         endcase
      end
      // Active copies move only at a frame boundary under the semaphore, or on soft reset below
      if (frame_end && commit_ff) begin
         nxt_pix_act = pix_sh_ff;
         nxt_lin_act = lin_sh_ff;
         nxt_abank_act = abank_sh_ff;
         nxt_wbank_act = wbank_sh_ff;
      end
      // Soft reset ignores stream state, so it can tear a frame in flight
      if (nxt_swrst) begin
         nxt_enable = 1'b0;
         nxt_commit = 1'b0;
         nxt_bypass = 1'b0;
         nxt_done = 1'b0;
         nxt_load_st = vdnc_pkg::VDNC_LD_RUN;
         nxt_load_cnt = 7'h00;
         nxt_pix_sh = DEF_PIXELS;
         nxt_lin_sh = DEF_LINES;
         nxt_abank_sh = DEF_ACT_BANK;
         nxt_wbank_sh = `VDNC_RST_WR_BANK;
         nxt_pix_act = DEF_PIXELS;
         nxt_lin_act = DEF_LINES;
         nxt_abank_act = DEF_ACT_BANK;
         nxt_wbank_act = `VDNC_RST_WR_BANK;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         enable_ff <= 1'b0;
         commit_ff <= 1'b0;
         bypass_ff <= 1'b0;
         swrst_ff <= 1'b0;
         done_ff <= 1'b0;
         load_st_ff <= vdnc_pkg::VDNC_LD_RUN;
         load_cnt_ff <= 7'h00;
         pix_sh_ff <= DEF_PIXELS;
         lin_sh_ff <= DEF_LINES;
         abank_sh_ff <= DEF_ACT_BANK;
         wbank_sh_ff <= `VDNC_RST_WR_BANK;
         pix_act_ff <= DEF_PIXELS;
         lin_act_ff <= DEF_LINES;
         abank_act_ff <= DEF_ACT_BANK;
         wbank_act_ff <= `VDNC_RST_WR_BANK;
      end else begin
         enable_ff <= nxt_enable;
         commit_ff <= nxt_commit;
         bypass_ff <= nxt_bypass;
         swrst_ff <= nxt_swrst;
         done_ff <= nxt_done;
         load_st_ff <= nxt_load_st;
         load_cnt_ff <= nxt_load_cnt;
         pix_sh_ff <= nxt_pix_sh;
         lin_sh_ff <= nxt_lin_sh;
         abank_sh_ff <= nxt_abank_sh;
         wbank_sh_ff <= nxt_wbank_sh;
         pix_act_ff <= nxt_pix_act;
         lin_act_ff <= nxt_lin_act;
         abank_act_ff <= nxt_abank_act;
         wbank_act_ff <= nxt_wbank_act;
      end
   end

   // ************************************************************
   // Read path
   // ************************************************************
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (reg_rd_en) begin
         case (reg_addr)
            `VDNC_OFS_CONTROL: begin
               nxt_rdata = ctrl_word(swrst_ff, bypass_ff, commit_ff, enable_ff);
            end
            `VDNC_OFS_STATUS: begin
               nxt_rdata = {31'h0000_0000, done_ff};
            end
            `VDNC_OFS_VERSION: begin
               nxt_rdata = {VER_MAJOR, VER_MINOR, VER_REVISION, VER_PATCH, VER_REV_NUM};
            end
            `VDNC_OFS_FRAME_DIM: begin
               nxt_rdata = {3'h0, lin_sh_ff, 3'h0, pix_sh_ff};
            end
            `VDNC_OFS_ACT_BANK: begin
               nxt_rdata = {29'h0000_0000, abank_sh_ff};
            end
            `VDNC_OFS_WR_BANK: begin
               nxt_rdata = {29'h0000_0000, wbank_sh_ff};
            end
            default: begin
               nxt_rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_ff <= 32'h0000_0000;
         rd_valid_ff <= 1'b0;
      end else begin
         rdata_ff <= nxt_rdata;
         rd_valid_ff <= reg_rd_en;
      end
   end

   // ************************************************************
   // Table memory
   // ************************************************************
   assign tbl.wr_en = load_accept;
   assign tbl.wr_addr = {wbank_sh_ff, load_cnt_ff};
   assign tbl.wr_data = reg_wdata[`VDNC_BYTE_MSB:0];
   assign tbl.rd_addr = {abank_act_ff, tbl_lookup_idx};

   vdnc_table_mem #(.DEPTH(1024)) u_mem (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .tbl(tbl.mem)
   );

   assign reg_rdata = rdata_ff;
   assign reg_rd_valid = rd_valid_ff;
   assign tbl_lookup_data = tbl.rd_data;
   assign processing_enable = enable_ff;
   assign filter_bypass = bypass_ff;
   assign core_reset = swrst_ff;
   assign active_pixels = pix_act_ff;
   assign active_lines = lin_act_ff;
   assign active_bank = abank_act_ff;
   assign active_write_bank = wbank_act_ff;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking vdnc_cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);

   a_enable_write: assert property (
      wr_ctrl && !reg_wdata[31] |=> processing_enable == $past(reg_wdata[0]))
      else $error("enable not taken");
   a_bypass_write: assert property (
      wr_ctrl && !reg_wdata[31] |=> filter_bypass == $past(reg_wdata[2]))
      else $error("bypass not taken");
   a_swrst_hold: assert property (
      core_reset |-> !processing_enable && !done_ff && active_pixels == DEF_PIXELS
         && active_bank == DEF_ACT_BANK)
      else $error("soft reset not holding");
   a_commit_copy: assert property (
      frame_end && commit_ff && !wr_ctrl && !swrst_ff
         |=> active_bank == $past(abank_sh_ff) && active_lines == $past(lin_sh_ff))
      else $error("commit missed");
   a_no_commit: assert property (
      !(frame_end && commit_ff) && !nxt_swrst
         |=> $stable(active_pixels) && $stable(active_bank))
      else $error("active changed");
   a_done_sticky: assert property (
      done_ff && !(wr_stat && reg_wdata[0]) && !nxt_swrst |=> done_ff)
      else $error("status dropped");
   a_load_done: assert property (
      load_accept && load_cnt_ff == 7'h7f && !nxt_swrst
         |=> done_ff && load_st_ff == vdnc_pkg::VDNC_LD_FULL)
      else $error("done not set");
   a_load_restart: assert property (
      wr_wbank && !swrst_ff
         |=> load_cnt_ff == 7'h00 && load_st_ff == vdnc_pkg::VDNC_LD_RUN)
      else $error("load not restarted");
   a_reserved_zero: assert property (
      reg_rd_en && reg_addr == 16'h0008 |=> reg_rd_valid && reg_rdata == 32'h0000_0000)
      else $error("reserved read nonzero");
   a_ctrl_readback: assert property (
      reg_rd_en && reg_addr == 16'h0000 |=> reg_rdata == {$past(swrst_ff), 28'h0000000,
         $past(bypass_ff), $past(commit_ff), $past(enable_ff)})
      else $error("control readback");
   a_version_read: assert property (
      reg_rd_en && reg_addr == 16'h0010
         |=> reg_rdata == {VER_MAJOR, VER_MINOR, VER_REVISION, VER_PATCH, VER_REV_NUM})
      else $error("version read");

   c_load_done: cover property (load_accept && load_cnt_ff == 7'h7f);
   c_commit: cover property (frame_end && commit_ff ##1 active_bank != $past(active_bank));
   c_soft_reset: cover property (core_reset ##1 !core_reset);
   c_status_clear: cover property (done_ff && wr_stat && reg_wdata[0]);
endmodule : vdnc_regs
`default_nettype wire

/* testbench/vdnc_stream_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Datapath stand-in
// ****************************************
// One end-of-frame pulse per rising request, so a held request cannot commit twice
module vdnc_stream_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Frame request and pulse
   input wire logic frame_req,
   output logic frame_end
);
   logic req_ff;
   logic end_ff;
   logic nxt_req;
   logic nxt_end;

   always_comb begin
      nxt_req = frame_req;
      nxt_end = frame_req & ~req_ff;
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         req_ff <= 1'b0;
         end_ff <= 1'b0;
      end else begin
         req_ff <= nxt_req;
         end_ff <= nxt_end;
      end
   end

   assign frame_end = end_ff;
endmodule : vdnc_stream_model
`default_nettype wire

/* testbench/tb_video_denoise_ctrl_regs.sv */
`timescale 1ns/10ps
`default_nettype none
`include "vdnc_params.svh"
module tb_video_denoise_ctrl_regs;
   // Identification values are arbitrary
   localparam logic [7:0] P_MAJ = 8'h12;
   localparam logic [7:0] P_MIN = 8'h34;
   localparam logic [3:0] P_REV = 4'h5;
   localparam logic [3:0] P_PAT = 4'h6;
   localparam logic [7:0] P_NUM = 8'h78;
   localparam logic [12:0] P_PIX = 13'h0321;
   localparam logic [12:0] P_LIN = 13'h0234;
   localparam logic [2:0] P_BANK = 3'h6;
   localparam logic [31:0] P_DIM = {3'h0, P_LIN, 3'h0, P_PIX};
   localparam logic [15:0] A_CTL = `VDNC_OFS_CONTROL;
   localparam logic [15:0] A_ST = `VDNC_OFS_STATUS;
   localparam logic [15:0] A_VER = `VDNC_OFS_VERSION;
   localparam logic [15:0] A_DIM = `VDNC_OFS_FRAME_DIM;
   localparam logic [15:0] A_TD = `VDNC_OFS_TBL_DATA;
   localparam logic [15:0] A_AB = `VDNC_OFS_ACT_BANK;
   localparam logic [15:0] A_WB = `VDNC_OFS_WR_BANK;

   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic reg_wr_en = 1'b0;
   logic reg_rd_en = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [31:0] reg_wdata = 32'h0;
   logic [31:0] reg_rdata;
   logic reg_rd_valid;
   logic frame_req = 1'b0;
   logic frame_end;
   logic [6:0] lk_idx = 7'h00;
   logic [7:0] lk_data;
   logic proc_en, byp, core_rst;
   logic [12:0] act_pix, act_lin;
   logic [2:0] act_bank, act_wbank;
   int n_fail = 0;
   int compares = 0;

   always #2.5 sys_clk = ~sys_clk;

   vdnc_regs #(.DEF_PIXELS(P_PIX), .DEF_LINES(P_LIN), .DEF_ACT_BANK(P_BANK),
      .VER_MAJOR(P_MAJ), .VER_MINOR(P_MIN), .VER_REVISION(P_REV),
      .VER_PATCH(P_PAT), .VER_REV_NUM(P_NUM)) u_dut (
      .sys_clk(sys_clk), .rst_b(rst_b),
      .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
      .frame_end(frame_end), .tbl_lookup_idx(lk_idx), .tbl_lookup_data(lk_data),
      .processing_enable(proc_en), .filter_bypass(byp), .core_reset(core_rst),
      .active_pixels(act_pix), .active_lines(act_lin), .active_bank(act_bank),
      .active_write_bank(act_wbank)
   );

   vdnc_stream_model u_stream (
      .sys_clk(sys_clk), .rst_b(rst_b), .frame_req(frame_req), .frame_end(frame_end)
   );

   // ****************************************
   // Access tasks
   // ****************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic report_and_stop();
      if (n_fail == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(negedge sys_clk);
      reg_wr_en = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge sys_clk);
      reg_wr_en = 1'b0;
   endtask : wr

   task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
      int i;
      @(negedge sys_clk);
      reg_rd_en = 1'b1;
      reg_addr = a;
      @(negedge sys_clk);
      reg_rd_en = 1'b0;
      for (i = 0; i < 4 && reg_rd_valid !== 1'b1; i++) begin
         @(negedge sys_clk);
      end
      if (reg_rd_valid !== 1'b1) begin
         n_fail++;
         report_and_stop();
      end else begin
         chk(reg_rdata, exp);
         // Read answer stands one cycle, then the port idles at zero
         @(negedge sys_clk);
         chk(32'(reg_rd_valid), 32'h0);
         chk(reg_rdata, 32'h0);
      end
   endtask : rd_chk

   task automatic frame();
      @(negedge sys_clk);
      frame_req = 1'b1;
      repeat (3) @(negedge sys_clk);
      frame_req = 1'b0;
   endtask : frame

   // Upper data bits set on purpose: only the low byte may be taken
   task automatic load(input int first, input int last, input logic [7:0] base);
      for (int k = first; k <= last; k++) begin
         wr(A_TD, {24'hffffff, base ^ 8'(k)});
      end
   endtask : load

   task automatic look(input logic [6:0] i, input logic [7:0] exp);
      @(negedge sys_clk);
      lk_idx = i;
      @(negedge sys_clk);
      chk(32'(lk_data), 32'(exp));
   endtask : look

   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_fail++;
      report_and_stop();
   end

   initial begin
      repeat (20) @(negedge sys_clk);
      rst_b = 1'b1;
      rd_chk(A_CTL, 32'h0);
      rd_chk(A_ST, 32'h0);
      rd_chk(A_VER, {P_MAJ, P_MIN, P_REV, P_PAT, P_NUM});
      rd_chk(A_DIM, P_DIM);
      rd_chk(A_AB, {29'h0, P_BANK});
      rd_chk(A_WB, 32'h0);
      chk(32'(act_bank), 32'(P_BANK));
      chk(32'(act_pix), 32'(P_PIX));
      wr(A_VER, 32'hffff_ffff);
      rd_chk(A_VER, {P_MAJ, P_MIN, P_REV, P_PAT, P_NUM});
      wr(16'h0008, 32'hffff_ffff);
      rd_chk(16'h0008, 32'h0);
      rd_chk(A_TD, 32'h0);
      wr(A_CTL, 32'h7fff_fffd);
      chk(32'(proc_en), 32'h1);
      chk(32'(byp), 32'h1);
      rd_chk(A_CTL, 32'h5);
      wr(A_CTL, 32'h0);
      chk(32'(proc_en), 32'h0);
      chk(32'(byp), 32'h0);
      wr(A_DIM, 32'hf123_e456);
      wr(A_AB, 32'h5);
      wr(A_WB, 32'h5);
      rd_chk(A_DIM, 32'h1123_0456);
      frame();
      chk(32'(act_pix), 32'(P_PIX));
      chk(32'(act_bank), 32'(P_BANK));
      wr(A_CTL, 32'h2);
      chk(32'(act_lin), 32'(P_LIN));
      frame();
      chk(32'(act_pix), 32'h456);
      chk(32'(act_lin), 32'h1123);
      chk(32'(act_bank), 32'h5);
      chk(32'(act_wbank), 32'h5);
      // Partial load, restart, then a full load into bank 5
      load(0, 9, 8'h3c);
      wr(A_WB, 32'h5);
      load(0, 126, 8'ha5);
      rd_chk(A_ST, 32'h0);
      load(127, 127, 8'ha5);
      frame();
      wr(A_ST, 32'hffff_fffe);
      rd_chk(A_ST, 32'h1);
      wr(A_ST, 32'h1);
      rd_chk(A_ST, 32'h0);
      for (int k = 0; k < 128; k += 63) look(7'(k), 8'ha5 ^ 8'(k));
      wr(A_TD, 32'h0);
      look(7'h00, 8'ha5);
      wr(A_WB, 32'h5);
      load(0, 127, 8'h5a);
      look(7'h7f, 8'h5a ^ 8'h7f);
      // Software reset only between frames, while status is set
      wr(A_CTL, 32'h8000_0007);
      chk(32'(proc_en), 32'h0);
      chk(32'(core_rst), 32'h1);
      chk(32'(act_pix), 32'(P_PIX));
      chk(32'(act_bank), 32'(P_BANK));
      wr(A_DIM, 32'h0040_0040);
      rd_chk(A_CTL, 32'h8000_0000);
      rd_chk(A_DIM, P_DIM);
      rd_chk(A_ST, 32'h0);
      wr(A_CTL, 32'h0);
      chk(32'(core_rst), 32'h0);
      rd_chk(A_AB, {29'h0, P_BANK});
      rd_chk(A_WB, 32'h0);
      report_and_stop();
   end
endmodule : tb_video_denoise_ctrl_regs
`default_nettype wire
